/* core/amfc_ctrl.v */
// Contract
// - select low enables speaker amplifier, select high enables headphone.
// - exactly one amplifier active; the other held in sleep.
// - mute is active low and silences the selected amplifier.
// - muted speaker amplifier turns on all low-side transistors.
// - shutdown is active low and puts the whole device in shutdown.
// - faults shown on two open-drain outputs as low and high bit.
// - code 11 no fault, lo0 hi1 undervoltage, 00 thermal.
// - pump undervoltage clamps low side; recovers automatically when gone.
// - undervoltage indication stays until mute, shutdown or supply cycled.
// - thermal fault clamps low side; recovers automatically when cooled.
// - thermal code stays after recovery until mute, shutdown, supply cycled.
// - thermal handling identical while headphone amplifier selected; code sets headphoneMute there instead of a low-side clamp.
// - headphone supply low disables headphone amp, reports no fault.
//
// Register access over APB and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "amfc_map.vh"
module amfc_ctrl (
  input  wire                    clk,
  input  wire                    rst_b,
  input  wire                    ampSelect,
  input  wire                    mute_b,
  input  wire                    shutdown_b,
  input  wire                    pumpUndervoltage,
  input  wire                    overTemp,
  input  wire                    headphoneSupplyLow,
  input  wire                    faultCodeLoIn,
  output reg                     faultCodeLoOut,
  output reg                     faultCodeLoOe_b,
  input  wire                    faultCodeHiIn,
  output reg                     faultCodeHiOut,
  output reg                     faultCodeHiOe_b,
  output reg                     speakerEnable,
  output reg                     headphoneEnable,
  output reg                     speakerSleep,
  output reg                     headphoneSleep,
  output reg                     lowSideClamp,
  output reg                     deviceShutdown,
  output reg                     headphoneMute,
  input  wire                    psel,
  input  wire                    penable,
  input  wire                    pwrite,
  input  wire [`AMFC_ADDR_W-1:0] paddr,
  input  wire [31:0]             pwdata,
  output reg  [31:0]             prdata,
  output reg                     pready,
  output reg                     pslverr,
  output reg                     irq
);

  wire [`AMFC_IN_W-1:0]    inSync;
  reg  [`AMFC_IN_W-1:0]    inPrev_reg;
  reg  [`AMFC_STATE_W-1:0] state_reg;
  reg  [`AMFC_STATE_W-1:0] state_next;
  reg                      uvLatch_reg;
  reg                      uvLatch_next;
  reg                      thLatch_reg;
  reg                      thLatch_next;
  reg  [`AMFC_CTRL_W-1:0]  ctrl_reg;
  reg  [`AMFC_EV_W-1:0]    evStat_reg;
  reg  [`AMFC_EV_W-1:0]    evStat_next;
  reg  [`AMFC_EV_W-1:0]    evMask_reg;
  reg  [31:0]              rdData;
  reg                      codeLo;
  reg                      codeHi;

  wire selHp;
  wire muteReq;
  wire shutReq;
  wire uvNow;
  wire thNow;
  wire hpLowNow;
  wire muteRelease;
  wire shutRelease;
  wire swClear;
  wire faultClear;
  wire apbWrite;
  wire [`AMFC_EV_W-1:0] evRise;

  // decode of the mapped register offsets
  function isReg;
    input [`AMFC_ADDR_W-1:0] a;
    begin
      isReg = (a == `AMFC_A_CTRL) || (a == `AMFC_A_STATUS) ||
              (a == `AMFC_A_IRQ_STAT) || (a == `AMFC_A_IRQ_MASK);
    end
  endfunction

  // rising edge between two successive samples
  function rose;
    input now;
    input prev;
    begin
      rose = now & ~prev;
    end
  endfunction

  // completed write aimed at one register
  function wrHit;
    input                    wr;
    input [`AMFC_ADDR_W-1:0] a;
    input [`AMFC_ADDR_W-1:0] target;
    begin
      wrHit = wr & (a == target);
    end
  endfunction

  amfc_sync #(
    .W       (`AMFC_IN_W),
    .RST_VAL (`AMFC_IN_RST)
  ) uInSync (
    .clk  (clk),
    .rst_b(rst_b),
    .dIn  ({headphoneSupplyLow, overTemp, pumpUndervoltage,
            shutdown_b, mute_b, ampSelect}),
    .dOut (inSync)
  );

  assign selHp    = inSync[`AMFC_IN_SEL];
  assign muteReq  = ~inSync[`AMFC_IN_MUTEB] |
                    ctrl_reg[`AMFC_CTRL_MUTE];
  assign shutReq  = ~inSync[`AMFC_IN_SHUTB];
  assign uvNow    = inSync[`AMFC_IN_UV];
  assign thNow    = inSync[`AMFC_IN_TH];
  assign hpLowNow = inSync[`AMFC_IN_HPLOW];

  // a release that follows an assertion clears latched faults
  assign muteRelease = rose(inSync[`AMFC_IN_MUTEB],
                            inPrev_reg[`AMFC_IN_MUTEB]);
  assign shutRelease = rose(inSync[`AMFC_IN_SHUTB],
                            inPrev_reg[`AMFC_IN_SHUTB]);
  assign apbWrite    = psel & penable & pready & pwrite;
  assign swClear     = wrHit(apbWrite, paddr, `AMFC_A_CTRL) &
                       pwdata[`AMFC_CTRL_CLEAR];
  assign faultClear  = muteRelease | shutRelease | swClear;

  assign evRise[`AMFC_EV_UV]    = rose(uvNow, inPrev_reg[`AMFC_IN_UV]);
  assign evRise[`AMFC_EV_TH]    = rose(thNow, inPrev_reg[`AMFC_IN_TH]);
  assign evRise[`AMFC_EV_HPLOW] = rose(hpLowNow,
                                       inPrev_reg[`AMFC_IN_HPLOW]);

  // fault latches: a live fault keeps setting, so set beats clear
  always @* begin
    uvLatch_next = uvNow | (uvLatch_reg & ~faultClear);
    thLatch_next = thNow | (thLatch_reg & ~faultClear);
  end

  // output stage state chosen from live conditions only
  always @* begin
    if (shutReq) begin
      state_next = `AMFC_S_SHUT;
    end else if (!selHp) begin
      if (muteReq || uvNow || thNow) begin
        state_next = `AMFC_S_CLAMP;
      end else begin
        state_next = `AMFC_S_SPK;
      end
    end else begin
      if (muteReq || thNow || hpLowNow) begin
        state_next = `AMFC_S_HPOFF;
      end else begin
        state_next = `AMFC_S_HP;
      end
    end
  end

  // fault code from the latches; thermal has priority
  always @* begin
    if (thLatch_next) begin
      codeLo = 1'b0;
      codeHi = 1'b0;
    end else if (uvLatch_next) begin
      codeLo = 1'b0;
      codeHi = 1'b1;
    end else begin
      codeLo = 1'b1;
      codeHi = 1'b1;
    end
  end

  always @* begin
    evStat_next = evStat_reg;
    if (wrHit(apbWrite, paddr, `AMFC_A_IRQ_STAT)) begin
      evStat_next = evStat_reg & ~pwdata[`AMFC_EV_W-1:0];
    end
    evStat_next = evStat_next | evRise;
  end

  always @* begin
    rdData = 32'h0000_0000;
    case (paddr)
      `AMFC_A_CTRL: begin
        rdData[`AMFC_CTRL_W-1:0] = ctrl_reg;
      end
      `AMFC_A_STATUS: begin
        rdData[`AMFC_ST_UV_LATCH] = uvLatch_reg;
        rdData[`AMFC_ST_TH_LATCH] = thLatch_reg;
        rdData[`AMFC_ST_CODE_LO]  = faultCodeLoOe_b;
        rdData[`AMFC_ST_CODE_HI]  = faultCodeHiOe_b;
        rdData[`AMFC_ST_STATE_MSB:`AMFC_ST_STATE_LSB] = state_reg;
        rdData[`AMFC_ST_PINS_MSB:`AMFC_ST_PINS_LSB]   = inSync;
        rdData[`AMFC_ST_PAD_LO]   = faultCodeLoIn;
        rdData[`AMFC_ST_PAD_HI]   = faultCodeHiIn;
      end
      `AMFC_A_IRQ_STAT: begin
        rdData[`AMFC_EV_W-1:0] = evStat_reg;
      end
      `AMFC_A_IRQ_MASK: begin
        rdData[`AMFC_EV_W-1:0] = evMask_reg;
      end
      default: begin
        rdData = 32'h0000_0000;
      end
    endcase
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      inPrev_reg  <= `AMFC_IN_RST;
      state_reg   <= `AMFC_S_SHUT;
      uvLatch_reg <= 1'b0;
      thLatch_reg <= 1'b0;
    end else begin
      inPrev_reg  <= inSync;
      state_reg   <= state_next;
      uvLatch_reg <= uvLatch_next;
      thLatch_reg <= thLatch_next;
    end
  end

  // registered outputs of the output stage
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      speakerEnable   <= 1'b0;
      headphoneEnable <= 1'b0;
      speakerSleep    <= 1'b1;
      headphoneSleep  <= 1'b1;
      lowSideClamp    <= 1'b0;
      deviceShutdown  <= 1'b1;
      headphoneMute   <= 1'b0;
    end else begin
      speakerEnable   <= (state_next == `AMFC_S_SPK);
      headphoneEnable <= (state_next == `AMFC_S_HP);
      speakerSleep    <= shutReq | selHp;
      headphoneSleep  <= shutReq | ~selHp;
      lowSideClamp    <= (state_next == `AMFC_S_CLAMP);
      deviceShutdown  <= (state_next == `AMFC_S_SHUT);
      headphoneMute   <= (state_next == `AMFC_S_HPOFF);
    end
  end

  // open-drain fault pins: enable low pulls the pin to ground
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      faultCodeLoOut  <= 1'b0;
      faultCodeHiOut  <= 1'b0;
      faultCodeLoOe_b <= 1'b1;
      faultCodeHiOe_b <= 1'b1;
    end else begin
      faultCodeLoOut  <= 1'b0;
      faultCodeHiOut  <= 1'b0;
      faultCodeLoOe_b <= codeLo;
      faultCodeHiOe_b <= codeHi;
    end
  end

  // apb slave: one wait state, answer in the second access cycle
  // pready gates the access so each transfer acts once
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~isReg(paddr);
      if (psel && penable && !pready && !pwrite) begin
        prdata <= rdData;
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_reg   <= `AMFC_CTRL_RST;
      evStat_reg <= `AMFC_EV_RST;
      evMask_reg <= `AMFC_EV_RST;
      irq        <= 1'b0;
    end else begin
      evStat_reg <= evStat_next;
      irq        <= |(evStat_next & evMask_reg);
      if (wrHit(apbWrite, paddr, `AMFC_A_CTRL)) begin
        ctrl_reg <= pwdata[`AMFC_CTRL_W-1:0];
      end
      if (wrHit(apbWrite, paddr, `AMFC_A_IRQ_MASK)) begin
        evMask_reg <= pwdata[`AMFC_EV_W-1:0];
      end
    end
  end

endmodule

/* core/amfc_map.vh */
`ifndef AMFC_MAP_VH
`define AMFC_MAP_VH

// apb register byte addresses
`define AMFC_ADDR_W        8
`define AMFC_A_CTRL        8'h00
`define AMFC_A_STATUS      8'h04
`define AMFC_A_IRQ_STAT    8'h08
`define AMFC_A_IRQ_MASK    8'h0C

// control register fields
`define AMFC_CTRL_MUTE     0
`define AMFC_CTRL_CLEAR    1
`define AMFC_CTRL_W        1
`define AMFC_CTRL_RST      1'h0

// status register fields
`define AMFC_ST_UV_LATCH   0
`define AMFC_ST_TH_LATCH   1
`define AMFC_ST_CODE_LO    2
`define AMFC_ST_CODE_HI    3
`define AMFC_ST_STATE_LSB  4
`define AMFC_ST_STATE_MSB  8
`define AMFC_ST_PINS_LSB   9
`define AMFC_ST_PINS_MSB   14
`define AMFC_ST_PAD_LO     15
`define AMFC_ST_PAD_HI     16

// interrupt status / mask fields
`define AMFC_EV_W          3
`define AMFC_EV_UV         0
`define AMFC_EV_TH         1
`define AMFC_EV_HPLOW      2
`define AMFC_EV_RST        3'h0

// synchronised input vector layout
`define AMFC_IN_W          6
`define AMFC_IN_SEL        0
`define AMFC_IN_MUTEB      1
`define AMFC_IN_SHUTB      2
`define AMFC_IN_UV         3
`define AMFC_IN_TH         4
`define AMFC_IN_HPLOW      5
// idle levels: select low, mute and shutdown released, no fault
`define AMFC_IN_RST        6'h06

// output-stage states, one-hot
`define AMFC_STATE_W       5
`define AMFC_S_SHUT        5'h01
`define AMFC_S_SPK         5'h02
`define AMFC_S_HP          5'h04
`define AMFC_S_CLAMP       5'h08
`define AMFC_S_HPOFF       5'h10

`endif

/* core/amfc_sync.v */
`timescale 1ns/1ps
// two-stage synchroniser for a vector of levels
module amfc_sync #(
  parameter W       = 1,
  parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
  input  wire         clk,
  input  wire         rst_b,
  input  wire [W-1:0] dIn,
  output reg  [W-1:0] dOut
);

  reg [W-1:0] meta_reg;

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_reg <= RST_VAL;
      dOut     <= RST_VAL;
    end else begin
      meta_reg <= dIn;
      dOut     <= meta_reg;
    end
  end

endmodule

/* verification/amfc_ctrl_assertions.sv */
`timescale 1ns/1ps
`include "amfc_map.vh"
module amfc_ctrl_checker (
  input wire logic                    clk,
  input wire logic                    rst_b,
  input wire logic                    ampSelect,
  input wire logic                    mute_b,
  input wire logic                    shutdown_b,
  input wire logic                    pumpUndervoltage,
  input wire logic                    overTemp,
  input wire logic                    headphoneSupplyLow,
  input wire logic                    faultCodeLoOe_b,
  input wire logic                    faultCodeHiOe_b,
  input wire logic                    speakerEnable,
  input wire logic                    headphoneEnable,
  input wire logic                    speakerSleep,
  input wire logic                    headphoneSleep,
  input wire logic                    lowSideClamp,
  input wire logic                    deviceShutdown,
  input wire logic                    headphoneMute,
  input wire logic                    psel,
  input wire logic                    penable,
  input wire logic                    pwrite,
  input wire logic [`AMFC_ADDR_W-1:0] paddr,
  input wire logic [31:0]             pwdata,
  input wire logic                    pready
);
  logic [3:0] clrAge_reg;
  logic       forceMute_reg;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // cycles since the last event that may clear a fault
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      clrAge_reg <= 4'hF;
    else if (!mute_b || !shutdown_b || pready)
      clrAge_reg <= 4'h0;
    else if (clrAge_reg != 4'hF)
      clrAge_reg <= clrAge_reg + 4'h1;
  end
  // copy of the software mute bit, taken when a write completes
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      forceMute_reg <= 1'b0;
    else if (psel && penable && pready && pwrite && paddr == `AMFC_A_CTRL)
      forceMute_reg <= pwdata[`AMFC_CTRL_MUTE];
  end
  sequence uvHeld;
    (pumpUndervoltage && !ampSelect && shutdown_b)[*4];
  endsequence
  sequence spkIdle;
    (!ampSelect && mute_b && shutdown_b && !forceMute_reg &&
     !pumpUndervoltage && !overTemp)[*4];
  endsequence
  sequence hpIdle;
    (ampSelect && mute_b && shutdown_b && !forceMute_reg &&
     !overTemp && !headphoneSupplyLow)[*4];
  endsequence
  sel_spk_a: assert property (spkIdle |->
    speakerEnable && headphoneSleep) else $error("speaker not enabled");
  sel_hp_a: assert property (hpIdle |->
    headphoneEnable && speakerSleep) else $error("headphone not enabled");
  one_amp_a: assert property (!deviceShutdown |->
    (speakerSleep ^ headphoneSleep) && !(speakerEnable && headphoneEnable))
    else $error("both amps active");
  mute_clamp_a: assert property (
    (!ampSelect && !mute_b && shutdown_b)[*4] |->
    lowSideClamp && !speakerEnable) else $error("mute without clamp");
  shut_all_a: assert property ((!shutdown_b)[*4] |->
    deviceShutdown && speakerSleep && headphoneSleep && !lowSideClamp)
    else $error("shutdown not entered");
  uv_code_a: assert property (uvHeld |->
    lowSideClamp && !faultCodeLoOe_b) else $error("undervoltage not handled");
  th_code_a: assert property ((overTemp && shutdown_b)[*4] |->
    !faultCodeLoOe_b && !faultCodeHiOe_b) else $error("thermal code wrong");
  hp_low_a: assert property (
    (ampSelect && headphoneSupplyLow && shutdown_b)[*4] |->
    !headphoneEnable && headphoneMute) else $error("hp supply low ignored");
  fault_sticky_a: assert property ($rose(faultCodeLoOe_b) |->
    clrAge_reg < 4'h6) else $error("fault code dropped without clear");
  th_sticky_a: assert property ($rose(faultCodeHiOe_b) |->
    clrAge_reg < 4'h6) else $error("thermal code dropped without clear");
  apb_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
endmodule
bind amfc_ctrl amfc_ctrl_checker amfc_ctrl_checker_i (
  .clk(clk), .rst_b(rst_b), .ampSelect(ampSelect), .mute_b(mute_b),
  .shutdown_b(shutdown_b), .pumpUndervoltage(pumpUndervoltage),
  .overTemp(overTemp), .headphoneSupplyLow(headphoneSupplyLow),
  .faultCodeLoOe_b(faultCodeLoOe_b), .faultCodeHiOe_b(faultCodeHiOe_b),
  .speakerEnable(speakerEnable), .headphoneEnable(headphoneEnable),
  .speakerSleep(speakerSleep), .headphoneSleep(headphoneSleep),
  .lowSideClamp(lowSideClamp), .deviceShutdown(deviceShutdown),
  .headphoneMute(headphoneMute), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready));

/* verification/amfc_pads.sv */
`timescale 1ns/1ps
// fault pins: open drain with board pull-ups
module amfc_pads (
  input  wire logic loOe_b,
  input  wire logic hiOe_b,
  output wire logic loWire,
  output wire logic hiWire
);
  assign loWire = loOe_b ? 1'b1 : 1'b0;
  assign hiWire = hiOe_b ? 1'b1 : 1'b0;
endmodule

/* verification/tb_amfc_ctrl.sv */
`timescale 1ns/1ps
`include "amfc_map.vh"
module tb_amfc_ctrl;
  logic        clk, rst_b, ampSelect, mute_b, shutdown_b, pumpUndervoltage;
  logic        overTemp, headphoneSupplyLow, psel, penable, pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic        loOe_b, hiOe_b, loW, hiW, spkEn, hpEn, spkSlp, hpSlp, clamp;
  logic        devShut, hpMute, pready, pslverr, irq, rerr, loOut, hiOut;
  int          mismatches, samples_checked;
  amfc_ctrl amfc_ctrl_i (.clk(clk), .rst_b(rst_b), .ampSelect(ampSelect),
    .mute_b(mute_b), .shutdown_b(shutdown_b), .overTemp(overTemp),
    .pumpUndervoltage(pumpUndervoltage),
    .headphoneSupplyLow(headphoneSupplyLow),
    .faultCodeLoIn(loW), .faultCodeLoOut(loOut), .faultCodeLoOe_b(loOe_b),
    .faultCodeHiIn(hiW), .faultCodeHiOut(hiOut), .faultCodeHiOe_b(hiOe_b),
    .speakerEnable(spkEn), .headphoneEnable(hpEn), .speakerSleep(spkSlp),
    .headphoneSleep(hpSlp), .lowSideClamp(clamp), .deviceShutdown(devShut),
    .headphoneMute(hpMute), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq));
  amfc_pads amfc_pads_i (.loOe_b(loOe_b), .hiOe_b(hiOe_b), .loWire(loW),
    .hiWire(hiW));
  always #10 clk = ~clk;
  task chk(input logic [32:0] seen, input logic [32:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task settle;
    repeat (4) @(posedge clk);
  endtask
  task t_regs;
    apb(1'b0, `AMFC_A_IRQ_MASK, 32'h0);
    chk({rerr, rdat}, 33'h0);
    apb(1'b0, `AMFC_A_IRQ_STAT, 32'h0);
    chk({rerr, rdat}, 33'h0);
    apb(1'b1, 8'h10, 32'hFFFFFFFF);
    chk(rerr, 1'b1);
    apb(1'b0, 8'h10, 32'h0);
    chk({rerr, rdat}, 33'h100000000);
  endtask
  task t_modes;
    for (int i = 0; i < 2; i++) begin
      ampSelect <= i[0];
      mute_b <= 1'b1;
      settle();
      chk({spkEn, hpEn, spkSlp, hpSlp}, i ? 4'h6 : 4'h9);
      mute_b <= 1'b0;
      settle();
      chk({clamp, spkEn, hpEn, hpMute}, i ? 4'h1 : 4'h8);
    end
    mute_b <= 1'b1;
    shutdown_b <= 1'b0;
    settle();
    chk({devShut, spkEn, hpEn, spkSlp, hpSlp}, 5'h13);
    shutdown_b <= 1'b1;
    ampSelect <= 1'b0;
    settle();
    apb(1'b1, `AMFC_A_CTRL, 32'h3);
    apb(1'b0, `AMFC_A_CTRL, 32'h0);
    chk(rdat, 32'h1);
    settle();
    chk({clamp, spkEn}, 2'h2);
    apb(1'b1, `AMFC_A_CTRL, 32'h0);
    settle();
    chk({clamp, spkEn}, 2'h1);
  endtask
  task t_uv;
    apb(1'b1, `AMFC_A_IRQ_MASK, 32'h7);
    pumpUndervoltage <= 1'b1;
    settle();
    chk({clamp, hiW, loW, irq}, 4'hD);
    chk({loOut, hiOut}, 2'h0);
    pumpUndervoltage <= 1'b0;
    settle();
    chk({clamp, spkEn, hiW, loW}, 4'h6);
    apb(1'b0, `AMFC_A_STATUS, 32'h0);
    chk(rdat, 32'h0001_0C29);
    apb(1'b1, `AMFC_A_IRQ_STAT, 32'h1);
    repeat (2) @(posedge clk);
    chk(irq, 1'b0);
    mute_b <= 1'b0;
    @(posedge clk);
    mute_b <= 1'b1;
    settle();
    chk({hiW, loW}, 2'h3);
  endtask
  task t_th;
    ampSelect <= 1'b1;
    overTemp <= 1'b1;
    pumpUndervoltage <= 1'b1;
    settle();
    chk({hiW, loW, hpMute}, 3'h1);
    overTemp <= 1'b0;
    pumpUndervoltage <= 1'b0;
    settle();
    chk({hiW, loW, hpEn}, 3'h1);
    apb(1'b1, `AMFC_A_CTRL, 32'h2);
    settle();
    chk({hiW, loW}, 2'h3);
    apb(1'b1, `AMFC_A_IRQ_STAT, 32'h7);
  endtask
  task t_hplow;
    apb(1'b1, `AMFC_A_IRQ_MASK, 32'h0);
    headphoneSupplyLow <= 1'b1;
    settle();
    chk({hpEn, hpMute, hiW, loW, irq}, 5'h0E);
    apb(1'b0, `AMFC_A_IRQ_STAT, 32'h0);
    chk(rdat, 32'h4);
    apb(1'b1, `AMFC_A_IRQ_MASK, 32'h4);
    @(posedge clk);
    chk(irq, 1'b1);
    headphoneSupplyLow <= 1'b0;
    apb(1'b1, `AMFC_A_IRQ_STAT, 32'h4);
    settle();
    chk({hpEn, irq}, 2'h2);
  endtask
  task conclude;
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #400000;
    mismatches++;
    conclude();
  end
  initial begin
    {clk, rst_b, ampSelect, pumpUndervoltage, overTemp} = 5'h0;
    {headphoneSupplyLow, psel, penable, pwrite, paddr, pwdata} = 44'h0;
    {mute_b, shutdown_b, mismatches, samples_checked} = 66'h3 << 64;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    t_regs();
    t_modes();
    t_uv();
    t_th();
    t_hplow();
    conclude();
  end
endmodule
